// File: inc/rsw_map.svh
/*
  Constants of the reset supervisor and watchdog: register addresses,
  reset values, field positions and timing counts.
  Assumes inclusion by its bare name from any design or bench file.
*/
`ifndef RSW_MAP_SVH
`define RSW_MAP_SVH

// special-function register addresses
`define RSW_KEY_ADDR 8'hAE
`define RSW_RELOAD_ADDR 8'hA6

// watchdog key: this value disables counting, and is loaded by any reset
`define RSW_KEY_DISABLE 8'h55
`define RSW_KEY_RST 8'h55

// watchdog counter layout and reset value
`define RSW_CNT_W 24
`define RSW_CNT_RST 24'h000000
`define RSW_CNT_ALL_ONES 24'hFFFFFF
`define RSW_CNT_LOW_CLR 16'h0000
`define RSW_CNT_HIGH_LSB 16

// core start address after release
`define RSW_START_ADDR 16'h0000

// power-up flag reset value (i_rst is the cold power-on reset)
`define RSW_PWR_FLAG_RST 1'b1

// machine cycle: default length in core clock periods
`define RSW_MCYC_BASE 3'h4

// timing: clock period and release delay after supply recovery
`define RSW_CLK_PERIOD_PS 4000
`define RSW_ACTV_DELAY_NS 10000

// cycles a watchdog timeout holds the core in reset
`define RSW_WDT_RST_CYC 8

`endif

// File: inc/rsw_pkg.sv
/*
  Types shared by the reset supervisor and watchdog modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rsw_pkg;

  // one bit per reset source
  typedef struct packed {
    logic ext_pin;
    logic low_supply;
    logic debug;
    logic watchdog;
  } rsw_req_type;

  // watchdog state visible to the rest of the chip
  typedef struct packed {
    logic        enabled;
    logic [7:0]  key;
    logic [23:0] count;
  } rsw_wdt_stat_type;

  // release sequencer states
  typedef enum logic [2:0] {
    RSW_ST_RUN   = 3'b001,
    RSW_ST_HOLD  = 3'b010,
    RSW_ST_DELAY = 3'b100
  } rsw_state_type;

endpackage : rsw_pkg

// File: verilog/rsw_sync.sv
/*
  Two flip-flop synchroniser, one chain per bit.
  Assumes inputs come from outside the clock domain; first stage is
  read only by the second stage.
*/
`timescale 1ns/1ps
`default_nettype none

module rsw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and control
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  // data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      logic meta_r;
      logic meta_nxt;
      logic stab_r;
      logic stab_nxt;

      // hold while the clock enable is low
      always_comb begin
        meta_nxt = i_ce ? i_async[g] : meta_r;
        stab_nxt = i_ce ? meta_r : stab_r;
      end

      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          meta_r <= RST_VAL[g];
          stab_r <= RST_VAL[g];
        end else begin
          meta_r <= meta_nxt;
          stab_r <= stab_nxt;
        end
      end

      assign o_sync[g] = stab_r;
    end
  endgenerate

endmodule // rsw_sync

`default_nettype wire

// File: verilog/rsw_mcycle.sv
/*
  Machine-cycle strobe generator for the watchdog.
  Assumes the core reports memory transfers, the configured bus cycle
  length and prefetch / branch-cache stalls on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rsw_map.svh"

module rsw_mcycle (
  // clock and control
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  // core timing inputs
  input wire logic i_mem_xfer,
  input wire logic [2:0] i_bus_periods,
  input wire logic i_stall,
  // one-cycle strobe at the end of each machine cycle
  output logic o_mcycle
);

  logic [2:0] phase_r;
  logic [2:0] phase_nxt;
  logic [2:0] len;
  logic last;

  // longer bus cycles stretch only machine cycles that move memory
  always_comb begin
    len = `RSW_MCYC_BASE;
    if (i_mem_xfer && (i_bus_periods > `RSW_MCYC_BASE)) begin
      len = i_bus_periods;
    end
    // a stall keeps the cycle open until it lifts
    last = (phase_r >= len - 3'h1) && !i_stall;
    phase_nxt = phase_r;
    if (i_ce) begin
      if (last) begin
        phase_nxt = 3'h0;
      end else if (phase_r < len - 3'h1) begin
        phase_nxt = phase_r + 3'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      phase_r <= 3'h0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign o_mcycle = i_ce && last;

endmodule // rsw_mcycle

`default_nettype wire

// File: verilog/rsw_top.sv
/*
  Reset supervisor and watchdog: merges pin, low-supply, debug and
  watchdog reset requests into the core reset and the active-low reset
  of the programmable logic module; holds the watchdog key and counter.
  Assumes a single 250 MHz core clock, firmware writes over the
  special-function register write port, and the core's idle and
  power-down levels on the same clock.
*/
// Operation
// - any of pin, low-supply, debug or watchdog requests raises the core reset.
// - the core is held while reset is high and starts at address 0000h after it.
// - an active-low reset to the programmable logic module follows the core reset.
// - a pin reset lasts exactly as long as the pin is held, with no stretch.
// - after supply recovery the reset stays for a fixed activation delay.
// - the low-supply detector is always active, in idle and power-down too.
// - a low-supply reset sets the power-up flag, which stays until software clears it.
// - the debug reset works in idle and power-down.
// - every reset loads 55h into the watchdog key, disabling the watchdog.
// - the watchdog is off while the key is 55h and on for any other value.
// - the watchdog is a 24-bit up-counter cleared to 000000h by every reset.
// - an enabled watchdog counts up by one per machine cycle.
// - wrapping past all ones issues a reset and restores 55h to the key.
// - a reload write sets the top 8 bits and clears the low 16 bits.
// - the watchdog does not count in idle or power-down.
// - a machine cycle is 4 clocks, longer for slow bus cycles or stalls.
`timescale 1ns/1ps
`default_nettype none
`include "rsw_map.svh"

module rsw_top #(
  parameter int ACTV_DELAY_CYC = (`RSW_ACTV_DELAY_NS * 1000) / `RSW_CLK_PERIOD_PS,
  parameter int WDT_RST_CYC = `RSW_WDT_RST_CYC
) (
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  // reset sources
  input wire logic i_ext_rst_n,
  input wire logic i_low_supply,
  input wire logic i_debug_rst,
  // core power modes
  input wire logic i_idle,
  input wire logic i_power_down,
  // machine-cycle timing from the core
  input wire logic i_mem_xfer,
  input wire logic [2:0] i_bus_periods,
  input wire logic i_stall,
  // special-function register write port
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  // power-up flag clear from software
  input wire logic i_power_flag_clr,
  // resets out
  output logic o_core_rst,
  output logic o_plm_rst_n,
  output logic [15:0] o_start_addr,
  // status
  output logic o_power_up_flag,
  output rsw_pkg::rsw_req_type o_rst_cause,
  output rsw_pkg::rsw_wdt_stat_type o_wdt_stat
);

  import rsw_pkg::*;

  localparam int ACTV_CYC = (ACTV_DELAY_CYC < 1) ? 1 : ACTV_DELAY_CYC;
  localparam int WRST_CYC = (WDT_RST_CYC < 1) ? 1 : WDT_RST_CYC;
  localparam int DLY_W = $clog2(ACTV_CYC + 1);
  localparam int WRST_W = $clog2(WRST_CYC + 1);

  // pin and detector levels cross into the clock domain
  logic ext_rst_n_s;
  logic low_supply_s;
  logic mcycle;

  rsw_sync #(
    .W(1),
    .RST_VAL(1'b1)
  ) u_sync_pin (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async(i_ext_rst_n),
    .o_sync(ext_rst_n_s)
  );

  // detector idles inactive, so a plain i_rst brings no release delay
  rsw_sync #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_sync_supply (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async(i_low_supply),
    .o_sync(low_supply_s)
  );

  rsw_mcycle u_mcycle (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_mem_xfer(i_mem_xfer),
    .i_bus_periods(i_bus_periods),
    .i_stall(i_stall),
    .o_mcycle(mcycle)
  );

  // release sequencer state
  rsw_state_type state_r;
  rsw_state_type state_nxt;
  logic [DLY_W-1:0] dly_r;
  logic [DLY_W-1:0] dly_nxt;
  logic supply_seen_r;
  logic supply_seen_nxt;
  logic core_rst_r;
  logic core_rst_nxt;
  rsw_req_type cause_r;
  rsw_req_type cause_nxt;
  logic pwr_flag_r;
  logic pwr_flag_nxt;

  // watchdog state
  logic [7:0] key_r;
  logic [7:0] key_nxt;
  logic [`RSW_CNT_W-1:0] cnt_r;
  logic [`RSW_CNT_W-1:0] cnt_nxt;
  logic [WRST_W-1:0] wrst_r;
  logic [WRST_W-1:0] wrst_nxt;

  rsw_req_type req;
  logic any_req;
  logic wdt_en;
  logic wdt_wrap;
  logic wdt_tick;
  logic key_wr;
  logic reload_wr;

  // request vector; idle and power-down gate neither detector nor debug
  always_comb begin
    req.ext_pin = !ext_rst_n_s;
    req.low_supply = low_supply_s;
    req.debug = i_debug_rst;
    req.watchdog = (wrst_r != '0);
    any_req = req.ext_pin || req.low_supply || req.debug || req.watchdog;
  end

  // sequencer: hold while any request, then delay only after low supply
  always_comb begin
    state_nxt = state_r;
    dly_nxt = dly_r;
    supply_seen_nxt = supply_seen_r;
    cause_nxt = cause_r;
    unique case (state_r)
      RSW_ST_RUN: begin
        if (any_req) begin
          state_nxt = RSW_ST_HOLD;
          cause_nxt = req;
          supply_seen_nxt = req.low_supply;
        end
      end
      RSW_ST_HOLD: begin
        cause_nxt = cause_r | req;
        supply_seen_nxt = supply_seen_r || req.low_supply;
        if (!any_req) begin
          if (supply_seen_r) begin
            state_nxt = RSW_ST_DELAY;
            dly_nxt = DLY_W'(ACTV_CYC - 1);
          end else begin
            state_nxt = RSW_ST_RUN;
          end
        end
      end
      RSW_ST_DELAY: begin
        if (any_req) begin
          state_nxt = RSW_ST_HOLD;
          cause_nxt = cause_r | req;
          supply_seen_nxt = supply_seen_r || req.low_supply;
        end else if (dly_r == '0) begin
          state_nxt = RSW_ST_RUN;
          supply_seen_nxt = 1'b0;
        end else begin
          dly_nxt = dly_r - DLY_W'(1);
        end
      end
    endcase
    // reset high while any request or pending delay remains
    core_rst_nxt = any_req || (state_nxt != RSW_ST_RUN);
    // a low clock enable freezes the sequencer whatever the requests do
    if (!i_ce) begin
      state_nxt = state_r;
      dly_nxt = dly_r;
      supply_seen_nxt = supply_seen_r;
      cause_nxt = cause_r;
      core_rst_nxt = core_rst_r;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_r <= RSW_ST_HOLD;
      dly_r <= '0;
      supply_seen_r <= 1'b0;
      cause_r <= '0;
      core_rst_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      dly_r <= dly_nxt;
      supply_seen_r <= supply_seen_nxt;
      cause_r <= cause_nxt;
      core_rst_r <= core_rst_nxt;
    end
  end

  // power-up flag: a new low-supply event wins over a same-cycle clear
  always_comb begin
    pwr_flag_nxt = pwr_flag_r;
    if (i_ce) begin
      if (req.low_supply) begin
        pwr_flag_nxt = 1'b1;
      end else if (i_power_flag_clr) begin
        pwr_flag_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pwr_flag_r <= `RSW_PWR_FLAG_RST;
    end else begin
      pwr_flag_r <= pwr_flag_nxt;
    end
  end

  // watchdog decode and counting
  always_comb begin
    key_wr = i_sfr_wr && (i_sfr_addr == `RSW_KEY_ADDR);
    reload_wr = i_sfr_wr && (i_sfr_addr == `RSW_RELOAD_ADDR);
    wdt_en = (key_r != `RSW_KEY_DISABLE);
    // no counting in idle or power-down
    wdt_tick = wdt_en && mcycle && !i_idle && !i_power_down;
    // overflow only on a real count step past all ones
    wdt_wrap = wdt_tick && (cnt_r == `RSW_CNT_ALL_ONES);
  end

  // a reload in the wrap cycle refreshes the count and averts the timeout
  always_comb begin
    key_nxt = key_r;
    cnt_nxt = cnt_r;
    wrst_nxt = wrst_r;
    if (i_ce) begin
      if (core_rst_r) begin
        key_nxt = `RSW_KEY_RST;
        cnt_nxt = `RSW_CNT_RST;
      end else begin
        if (key_wr) begin
          key_nxt = i_sfr_wdata;
        end
        if (reload_wr) begin
          cnt_nxt = {i_sfr_wdata, `RSW_CNT_LOW_CLR};
        end else if (wdt_wrap) begin
          key_nxt = `RSW_KEY_DISABLE;
          cnt_nxt = `RSW_CNT_RST;
          wrst_nxt = WRST_W'(WRST_CYC);
        end else if (wdt_tick) begin
          cnt_nxt = cnt_r + `RSW_CNT_W'(1);
        end
      end
      // timeout pulse is stretched so the sequencer always sees it
      if (wrst_r != '0) begin
        wrst_nxt = wrst_r - WRST_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      key_r <= `RSW_KEY_RST;
      cnt_r <= `RSW_CNT_RST;
      wrst_r <= '0;
    end else begin
      key_r <= key_nxt;
      cnt_r <= cnt_nxt;
      wrst_r <= wrst_nxt;
    end
  end

  // outputs from flip-flops; the start address is fixed
  assign o_core_rst = core_rst_r;
  assign o_plm_rst_n = !core_rst_r;
  assign o_start_addr = `RSW_START_ADDR;
  assign o_power_up_flag = pwr_flag_r;
  // cause holds the sources of the last reset until the next one begins
  assign o_rst_cause = cause_r;
  // status enable shares the decode, so it cannot drift from counting
  assign o_wdt_stat = '{enabled: wdt_en, key: key_r, count: cnt_r};

endmodule // rsw_top

`default_nettype wire

// File: tb/rsw_top_sva.sv
/*
  Port-level checks of the reset supervisor and watchdog top.
  Assumes a bind to rsw_top, one clock and a synchronous i_rst.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rsw_map.svh"

module rsw_chk (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  // inputs of the block
  input wire logic i_ext_rst_n,
  input wire logic i_debug_rst,
  input wire logic i_idle,
  input wire logic i_power_down,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  // outputs under check
  input wire logic o_core_rst,
  input wire logic o_plm_rst_n,
  input wire logic [15:0] o_start_addr,
  input wire rsw_pkg::rsw_wdt_stat_type o_wdt_stat
);
  import rsw_pkg::*;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // parked core with nothing else able to move the count
  logic quiet;
  assign quiet = (i_idle || i_power_down) && !i_sfr_wr && !o_core_rst && !i_debug_rst;
  // overflow step, then the stretched timeout reset
  sequence s_wrap;
    $past(o_wdt_stat.count) == `RSW_CNT_ALL_ONES && $fell(o_wdt_stat.enabled);
  endsequence
  sequence s_hold;
    o_core_rst [*8];
  endsequence
  property p_plm;
    o_plm_rst_n != o_core_rst;
  endproperty
  property p_start;
    $fell(o_core_rst) |-> o_start_addr == `RSW_START_ADDR;
  endproperty
  property p_en;
    o_wdt_stat.enabled == (o_wdt_stat.key != `RSW_KEY_DISABLE);
  endproperty
  property p_pin;
    !i_ext_rst_n [*3] |=> o_core_rst;
  endproperty
  property p_dbg;
    i_debug_rst |=> o_core_rst;
  endproperty
  property p_rkey;
    o_core_rst [*2] |-> o_wdt_stat.key == `RSW_KEY_RST && o_wdt_stat.count == `RSW_CNT_RST;
  endproperty
  property p_reload;
    i_ce && i_sfr_wr && i_sfr_addr == `RSW_RELOAD_ADDR && !o_core_rst
      |=> o_core_rst || o_wdt_stat.count == {$past(i_sfr_wdata), 16'h0000};
  endproperty
  // a reset may clear the count a cycle early, so zero is let through
  property p_step;
    !o_core_rst && !i_sfr_wr |=> o_core_rst || o_wdt_stat.count == 24'h000000
      || o_wdt_stat.count == $past(o_wdt_stat.count) || o_wdt_stat.count == $past(o_wdt_stat.count) + 24'h000001;
  endproperty
  property p_park;
    quiet [*2] |=> $stable(o_wdt_stat.count);
  endproperty
  property p_wrap;
    s_wrap |-> o_wdt_stat.count == `RSW_CNT_RST ##1 s_hold;
  endproperty
  a_plm: assert property (p_plm) else $error("logic reset not inverse of core reset");
  a_start: assert property (p_start) else $error("start address wrong at release");
  a_en: assert property (p_en) else $error("enable disagrees with key");
  a_pin: assert property (p_pin) else $error("pin reset not taken");
  a_dbg: assert property (p_dbg) else $error("debug reset not taken");
  a_rkey: assert property (p_rkey) else $error("key or count not reloaded in reset");
  a_reload: assert property (p_reload) else $error("reload value wrong");
  a_step: assert property (p_step) else $error("count moved by more than one");
  a_park: assert property (p_park) else $error("count moved while parked");
  a_wrap: assert property (p_wrap) else $error("overflow did not reset");
endmodule // rsw_chk
`default_nettype wire

// File: tb/rsw_fw_model.sv
/*
  Firmware and reset-pin model: register writes, pin pulses, flag clear.
  Assumes calls from the bench; drives only after falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module rsw_fw (
  // clock
  input wire logic i_clk_sys,
  // register writes, pin and flag clear
  output logic o_sfr_wr,
  output logic [7:0] o_sfr_addr,
  output logic [7:0] o_sfr_wdata,
  output logic o_ext_rst_n,
  output logic o_power_flag_clr
);
  // idle levels; pin pulled up
  initial begin
    o_sfr_wr = 1'b0;
    o_sfr_addr = 8'h00;
    o_sfr_wdata = 8'h00;
    o_ext_rst_n = 1'b1;
    o_power_flag_clr = 1'b0;
  end
  // one write cycle; stale data scrambled so it is never reused by luck
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_sfr_wr = 1'b1;
    o_sfr_addr = a;
    o_sfr_wdata = d;
    @(negedge i_clk_sys);
    o_sfr_wr = 1'b0;
    o_sfr_wdata = ~d;
  endtask
  // pin held low for n cycles
  task automatic pin_pulse(input int n);
    @(negedge i_clk_sys);
    o_ext_rst_n = 1'b0;
    repeat (n) @(negedge i_clk_sys);
    o_ext_rst_n = 1'b1;
  endtask
  // software clear of the power-up flag
  task automatic flag_clear;
    @(negedge i_clk_sys);
    o_power_flag_clr = 1'b1;
    @(negedge i_clk_sys);
    o_power_flag_clr = 1'b0;
  endtask
endmodule // rsw_fw
`default_nettype wire

// File: tb/rsw_top_tb_top.sv
/*
  Self-checking bench of the reset supervisor and watchdog.
  Assumes rsw_top, rsw_fw and rsw_chk compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rsw_map.svh"

module rsw_top_tb_top;
  import rsw_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic low = 1'b0, dbg = 1'b0, idle = 1'b0, pd = 1'b0, mx = 1'b0, ce = 1'b1, stl = 1'b0;
  logic [2:0] bp = 3'h4;
  wire logic wr, pin_n, fclr;
  wire logic [7:0] addr, wdat;
  logic core_rst, plm_n, pflag;
  logic [15:0] sa;
  rsw_req_type cause;
  rsw_wdt_stat_type ws;
  int error_cnt = 0, checked = 0, n;
  always #2 i_clk_sys = ~i_clk_sys;
  // short release delay keeps the run brief
  rsw_top #(.ACTV_DELAY_CYC(4), .WDT_RST_CYC(8)) i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(ce),
    .i_ext_rst_n(pin_n), .i_low_supply(low), .i_debug_rst(dbg), .i_idle(idle), .i_power_down(pd),
    .i_mem_xfer(mx), .i_bus_periods(bp), .i_stall(stl), .i_sfr_wr(wr), .i_sfr_addr(addr),
    .i_sfr_wdata(wdat), .i_power_flag_clr(fclr), .o_core_rst(core_rst), .o_plm_rst_n(plm_n),
    .o_start_addr(sa), .o_power_up_flag(pflag), .o_rst_cause(cause), .o_wdt_stat(ws));
  rsw_fw i_fw (.i_clk_sys(i_clk_sys), .o_sfr_wr(wr), .o_sfr_addr(addr), .o_sfr_wdata(wdat),
    .o_ext_rst_n(pin_n), .o_power_flag_clr(fclr));
  task automatic wrap_up;
    $display("errors %0d of %0d checks", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge i_clk_sys);
  endtask
  // bounded wait for a core reset level, n = cycles spent
  task automatic wait_rst(input logic lvl, output int c);
    c = 0;
    while (core_rst !== lvl && c < 200) begin
      cyc(1);
      c++;
    end
    if (c >= 200) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  // count advance over k cycles
  task automatic rate(input int k, input logic [23:0] exp);
    logic [23:0] c0;
    c0 = ws.count;
    cyc(k);
    chk(ws.count - c0, exp);
  endtask
  task automatic t_count;
    i_fw.sfr_write(`RSW_KEY_ADDR, 8'hAA);
    i_fw.sfr_write(`RSW_RELOAD_ADDR, 8'h04);
    chk(ws, {1'b1, 8'hAA, 24'h040000});
    rate(40, 24'h00000A);
    mx = 1'b1;
    bp = 3'h6;
    cyc(12);
    rate(60, 24'h00000A);
    mx = 1'b0;
    stl = 1'b1;
    rate(20, 24'h000000);
    stl = 1'b0;
    ce = 1'b0;
    rate(20, 24'h000000);
    ce = 1'b1;
    idle = 1'b1;
    cyc(2);
    rate(20, 24'h000000);
    idle = 1'b0;
    pd = 1'b1;
    cyc(2);
    rate(20, 24'h000000);
    pd = 1'b0;
    i_fw.sfr_write(8'h00, 8'h55);
    chk(ws.key, 8'hAA);
    i_fw.sfr_write(`RSW_KEY_ADDR, 8'h55);
    chk(ws.enabled, 1'b0);
  endtask
  task automatic t_pin;
    i_fw.sfr_write(`RSW_KEY_ADDR, 8'hAA);
    fork
      i_fw.pin_pulse(6);
      begin
        wait_rst(1'b1, n);
        wait_rst(1'b0, n);
      end
    join
    chk(n, 6);
    chk(ws, {1'b0, 8'h55, 24'h000000});
    chk(cause, 4'h8);
  endtask
  task automatic t_debug;
    i_fw.sfr_write(`RSW_KEY_ADDR, 8'h33);
    idle = 1'b1;
    pd = 1'b1;
    dbg = 1'b1;
    cyc(3);
    chk(core_rst, 1'b1);
    chk(ws, {1'b0, 8'h55, 24'h000000});
    chk(cause, 4'h2);
    dbg = 1'b0;
    wait_rst(1'b0, n);
    idle = 1'b0;
  endtask
  // supply drop while powered down: flag set, release delayed
  task automatic t_supply;
    i_fw.flag_clear();
    chk(pflag, 1'b0);
    low = 1'b1;
    cyc(6);
    chk({core_rst, plm_n}, 2'b10);
    low = 1'b0;
    wait_rst(1'b0, n);
    chk(n >= 7 && n <= 8, 1'b1);
    chk(pflag, 1'b1);
    chk(cause, 4'h4);
    pd = 1'b0;
  endtask
  initial begin
    cyc(4);
    i_rst = 1'b0;
    cyc(3);
    chk({ws, pflag, sa}, {1'b0, 8'h55, 24'h000000, 1'b1, 16'h0000});
    chk({core_rst, plm_n}, 2'b01);
    t_count();
    t_pin();
    t_debug();
    t_supply();
    wrap_up();
  end
endmodule // rsw_top_tb_top

bind rsw_top rsw_chk i_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_ext_rst_n(i_ext_rst_n),
  .i_debug_rst(i_debug_rst), .i_idle(i_idle), .i_power_down(i_power_down), .i_sfr_wr(i_sfr_wr),
  .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata), .o_core_rst(o_core_rst),
  .o_plm_rst_n(o_plm_rst_n), .o_start_addr(o_start_addr), .o_wdt_stat(o_wdt_stat));
`default_nettype wire
